// File: sadc_control.v
// serial converter control logic with result fifo
// assumes select, transfer clock, address and conversion clock come from pins
//
// Operation
// - tenth falling edge starts 44-cycle conversion
// - msb appears when select goes low
// - nine more bits on falling edges
// - ignore controls three cycles after select falls
// - address sampled on transfer-clock rising edges
// - twelve-way selector, eleven external plus self-test
// - clamp to all ones or zeros
// - select high: output off, transfer clock and address ignored, a running conversion still counts conversion clock
// - four-bit address msb first on rises
// - address 1011 selects self-test input
// - select falling during conversion aborts it
`timescale 1ns/1ps
`include "sadc_defs.vh"

// ----------------------------------------------------------------------------
// result fifo
// ----------------------------------------------------------------------------
module sadc_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clock,
    input  wire             rstN,
    input  wire             clkEn,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    output reg  [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wrPtr_q;
    reg [AW:0]      rdPtr_q;
    wire            empty = (wrPtr_q == rdPtr_q);
    wire            full  = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
    wire            doWr  = inValid && !full;
    wire            doRd  = !empty && outReady;

    assign inReady  = !full;
    assign outValid = !empty;

    always @(posedge clock) begin
        if (clkEn && doWr) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always @* begin
        outData = mem[rdPtr_q[AW-1:0]];
    end

    always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            wrPtr_q <= {(AW+1){1'b0}};
            rdPtr_q <= {(AW+1){1'b0}};
        end else if (clkEn) begin
            if (doWr) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doRd) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule // sadc_fifo

// ----------------------------------------------------------------------------
// control top
// ----------------------------------------------------------------------------
module sadc_control #(
    parameter RES_BITS    = `SADC_RES_BITS,
    parameter CONV_CYCLES = `SADC_CONV_CYCLES,
    parameter FIFO_DEPTH  = `SADC_FIFO_DEPTH
) (
    input  wire                clock,
    input  wire                rst_n,
    input  wire                clkEn,
    input  wire                selectN,
    input  wire                xferClk,
    input  wire                addrIn,
    input  wire                convClk,
    output reg                 dataOut,
    output reg                 dataOutEn,
    output reg  [11:0]         chanSel,
    output reg                 sampling,
    input  wire [RES_BITS-1:0] sampleCode,
    input  wire                overRange,
    input  wire                underRange,
    output wire                sampleReady,
    input  wire                sampleValid,
    output reg                 convBusy,
    output reg  [RES_BITS-1:0] resultWord,
    output reg                 resultPulse
);
    localparam ST_IDLE   = 4'b0001;
    localparam ST_FILTER = 4'b0010;
    localparam ST_XFER   = 4'b0100;
    localparam ST_CONV   = 4'b1000;

    // ------------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------------
    reg       rstMeta_q, rstSync_q;
    reg [3:0] pinMeta_q, pinSync_q;
    reg       xferOld_q, convOld_q, selOld_q;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    always @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            pinMeta_q <= 4'h1;
            pinSync_q <= 4'h1;
            xferOld_q <= 1'b0;
            convOld_q <= 1'b0;
            selOld_q  <= 1'b1;
        end else if (clkEn) begin
            pinMeta_q <= {convClk, addrIn, xferClk, selectN};
            pinSync_q <= pinMeta_q;
            xferOld_q <= pinSync_q[1];
            convOld_q <= pinSync_q[3];
            selOld_q  <= pinSync_q[0];
        end
    end

    wire selLow   = !pinSync_q[0];
    wire selFall  = selOld_q && !pinSync_q[0];
    wire xferRise = !xferOld_q && pinSync_q[1];
    wire xferFall = xferOld_q && !pinSync_q[1];
    wire convRise = !convOld_q && pinSync_q[3];

    // clamp the raw code at the reference limits
    function [RES_BITS-1:0] clampCode;
        input [RES_BITS-1:0] code;
        input                over;
        input                under;
        begin
            if (over) begin
                clampCode = {RES_BITS{1'b1}};
            end else if (under) begin
                clampCode = {RES_BITS{1'b0}};
            end else begin
                clampCode = code;
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // sample fifo between converter core and output register
    // ------------------------------------------------------------------------
    reg [3:0]          state_q;
    reg [1:0]          filt_q;
    reg [3:0]          edges_q;
    reg [5:0]          convCnt_q;
    reg [3:0]          addrShift_q;
    reg [3:0]          addr_q;
    reg [RES_BITS-1:0] shift_q;
    reg [RES_BITS-1:0] result_q;
    wire [RES_BITS-1:0] fifoData;
    wire                fifoValid;
    // pop one code exactly when a conversion completes, never on an abort
    wire                fifoTake = (state_q == ST_CONV) && convRise && !selFall &&
                                   (convCnt_q == CONV_CYCLES - 1);
    wire [RES_BITS-1:0] newRes   = fifoValid ? fifoData : result_q;

    sadc_fifo #(
        .WIDTH (RES_BITS),
        .DEPTH (FIFO_DEPTH),
        .AW    ($clog2(FIFO_DEPTH))
    ) uFifo (
        .clock    (clock),
        .rstN     (rstSync_q),
        .clkEn    (clkEn),
        .inData   (clampCode(sampleCode, overRange, underRange)),
        .inValid  (sampleValid),
        .inReady  (sampleReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoTake)
    );

    // ------------------------------------------------------------------------
    // transfer and conversion sequencer
    // ------------------------------------------------------------------------

    always @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            state_q     <= ST_IDLE;
            filt_q      <= 2'h0;
            edges_q     <= 4'h0;
            convCnt_q   <= 6'h00;
            addrShift_q <= 4'h0;
            addr_q      <= 4'h0;
            shift_q     <= `SADC_RESULT_RESET;
            result_q    <= `SADC_RESULT_RESET;
            dataOut     <= 1'b0;
            dataOutEn   <= 1'b0;
            chanSel     <= 12'h001;
            sampling    <= 1'b0;
            convBusy    <= 1'b0;
            resultWord  <= `SADC_RESULT_RESET;
            resultPulse <= 1'b0;
        end else if (clkEn) begin
            resultPulse <= 1'b0;
            dataOutEn <= selLow;
            if (selFall) begin
                // a fresh select aborts any running conversion
                state_q  <= ST_FILTER;
                convBusy <= 1'b0;
                sampling <= 1'b0;
                filt_q   <= 2'h0;
                edges_q  <= 4'h0;
                shift_q  <= result_q;
                dataOut  <= result_q[RES_BITS-1];
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        sampling <= 1'b0;
                    end
                    ST_FILTER: begin
                        if (!selLow) begin
                            state_q <= ST_IDLE;
                        end else if (convRise) begin
                            filt_q <= filt_q + 2'h1;
                            if (filt_q == `SADC_FILTER_CYCLES - 1) begin
                                state_q <= ST_XFER;
                            end
                        end
                    end
                    ST_XFER: begin
                        if (!selLow) begin
                            state_q <= ST_IDLE;
                        end else begin
                            if (xferRise && edges_q < `SADC_ADDR_EDGES) begin
                                addrShift_q <= {addrShift_q[2:0], pinSync_q[2]};
                            end
                            if (xferFall) begin
                                edges_q <= edges_q + 4'h1;
                                shift_q <= {shift_q[RES_BITS-2:0], 1'b0};
                                dataOut <= shift_q[RES_BITS-2];
                                if (edges_q == `SADC_ADDR_EDGES - 1) begin
                                    addr_q   <= addrShift_q;
                                    sampling <= 1'b1;
                                end
                                if (edges_q == `SADC_XFER_EDGES - 1) begin
                                    state_q   <= ST_CONV;
                                    sampling  <= 1'b0;
                                    convBusy  <= 1'b1;
                                    convCnt_q <= 6'h00;
                                end
                            end
                        end
                    end
                    ST_CONV: begin
                        // the host keeps the transfer clock low meanwhile
                        if (convRise) begin
                            convCnt_q <= convCnt_q + 6'h01;
                            if (convCnt_q == CONV_CYCLES - 1) begin
                                state_q     <= selLow ? ST_FILTER : ST_IDLE;
                                convBusy    <= 1'b0;
                                result_q    <= newRes;
                                resultWord  <= newRes;
                                resultPulse <= 1'b1;
                                edges_q     <= 4'h0;
                                shift_q     <= newRes;
                                dataOut     <= newRes[RES_BITS-1];
                                filt_q      <= 2'h0;
                            end
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
            // selector: one-hot, self-test at top position, all zero for addresses 12 to 15
            if (addr_q == `SADC_SELFTEST_ADDR) begin
                chanSel <= 12'h800;
            end else if (addr_q < `SADC_EXT_CHANNELS) begin
                chanSel <= 12'h001 << addr_q;
            end else begin
                chanSel <= 12'h000;
            end
        end
    end
endmodule // sadc_control

// File: sadc_control_bench.sv
// self-checking bench for the converter control top
// assumes the host model drives the pins; bench feeds codes
`timescale 1ns/1ps
module sadc_control_bench;
    reg         clock, rst_n, sampleValid, overRange, underRange;
    reg  [9:0]  sampleCode, lastRes;
    wire        selectN, xferClk, addrIn, convClk, dataOut, dataOutEn;
    wire        sampling, sampleReady, convBusy, resultPulse;
    wire [11:0] chanSel;
    wire [9:0]  resultWord;
    integer     n_errors, n_tests, k;
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    sadc_host_model hostU (.clock(clock), .dataOut(dataOut), .selectN(selectN), .xferClk(xferClk),
        .addrIn(addrIn), .convClk(convClk));
    sadc_control dut_u (.clock(clock), .rst_n(rst_n), .clkEn(1'b1), .selectN(selectN), .xferClk(xferClk),
        .addrIn(addrIn), .convClk(convClk), .dataOut(dataOut), .dataOutEn(dataOutEn), .chanSel(chanSel),
        .sampling(sampling), .sampleCode(sampleCode), .overRange(overRange), .underRange(underRange),
        .sampleReady(sampleReady), .sampleValid(sampleValid), .convBusy(convBusy),
        .resultWord(resultWord), .resultPulse(resultPulse));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function [9:0] rawOf(input integer i);
        rawOf = 10'h2a5 ^ (i[9:0] * 10'h025);
    endfunction
    task check(input [8*6:1] nm, input [11:0] seen, input [11:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("BAD %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task finish_test;
        begin
            $display("mismatches %0d of %0d checks", n_errors, n_tests);
            if (n_errors == 0 && n_tests > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task wait_pulse(output [9:0] w);
        integer i;
        reg ok;
        begin
            ok = 1'b0;
            for (i = 0; i < 400 && !ok; i = i + 1) begin
                @(posedge clock) #1;
                if (resultPulse === 1'b1) begin
                    ok = 1'b1;
                    w = resultWord;
                end
            end
            if (!ok) begin
                n_errors = n_errors + 1;
                finish_test;
            end
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_fill;
        integer i;
        begin
            for (i = 0; i < 40 && sampleReady === 1'b1; i = i + 1) begin
                sampleCode = rawOf(i);
                overRange = (i == 5);
                underRange = (i == 6);
                sampleValid = 1'b1;
                @(negedge clock);
            end
            sampleValid = 1'b0;
            overRange = 1'b0;
            underRange = 1'b0;
            check("fill", i[11:0], 12'h020);
            check("full", {11'h0, sampleReady}, 12'h000);
        end
    endtask
    task t_conv(input integer n);
        reg [9:0] rx, w, e;
        begin
            @(negedge clock);
            e = (n == 5) ? 10'h3ff : (n == 6) ? 10'h000 : rawOf(n);
            overRange = (n == 5);
            underRange = (n == 6);
            hostU.xfer(n[3:0], rx);
            check("chan", chanSel, (n[3:0] < 4'hc) ? 12'h001 << n[3:0] : 12'h000);
            wait_pulse(w);
            check("result", {2'b00, w}, {2'b00, e});
            if (n > 0)
                check("shift", {2'b00, rx}, {2'b00, lastRes});
            lastRes = e;
            overRange = 1'b0;
            underRange = 1'b0;
            hostU.deselect(44);
        end
    endtask
    task t_idle;
        reg [11:0] c;
        begin
            c = chanSel;
            hostU.wiggle;
            check("dsel", {11'h0, dataOutEn}, 12'h000);
            check("hold", chanSel, c);
        end
    endtask
    task t_abort;
        reg [9:0] rx;
        integer i, p;
        begin
            hostU.xfer(4'h2, rx);
            repeat (20) @(negedge clock);
            check("busy", {11'h0, convBusy}, 12'h001);
            hostU.deselect(1);
            hostU.select_low;
            p = 0;
            for (i = 0; i < 250; i = i + 1) begin
                @(negedge clock);
                p = p + (resultPulse === 1'b1);
            end
            check("idle", {11'h0, convBusy}, 12'h000);
            check("pulse", p[11:0], 12'h000);
            hostU.deselect(4);
        end
    endtask
    initial begin
        #2000000;
        n_errors = n_errors + 1;
        finish_test;
    end
    initial begin
        n_errors = 0;
        n_tests = 0;
        rst_n = 1'b0;
        sampleValid = 1'b0;
        sampleCode = 10'h000;
        overRange = 1'b0;
        underRange = 1'b0;
        lastRes = 10'h000;
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        check("rsten", {11'h0, dataOutEn}, 12'h000);
        check("rstch", chanSel, 12'h001);
        t_fill;
        for (k = 0; k < 32; k = k + 1)
            t_conv(k);
        check("drain", {11'h0, sampleReady}, 12'h001);
        t_idle;
        t_abort;
        finish_test;
    end
endmodule // sadc_control_bench

// File: sadc_defs.vh
// constants for the serial converter control block
// assumes inclusion by bare name from the design file
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH

`define SADC_RES_BITS      10
`define SADC_ADDR_BITS     4
`define SADC_CONV_CYCLES   44
`define SADC_FILTER_CYCLES 3
`define SADC_XFER_EDGES    10
`define SADC_ADDR_EDGES    4
`define SADC_SELFTEST_ADDR 4'hb
`define SADC_EXT_CHANNELS  11
`define SADC_FIFO_DEPTH    32
`define SADC_RESULT_RESET  10'h000

`endif

// File: sadc_host_model.sv
// host side of the serial pins: select, transfer and conversion clocks
// assumes a 50 MHz clock; changes pins on its falling edge
`timescale 1ns/1ps
module sadc_host_model (
    input  wire clock,
    input  wire dataOut,
    output reg  selectN,
    output reg  xferClk,
    output reg  addrIn,
    output reg  convClk
);
    initial begin
        selectN = 1'b1;
        xferClk = 1'b0;
        addrIn = 1'b0;
        convClk = 1'b0;
        forever #40 convClk = ~convClk;
    end
    // deselected address line does not hold its last value
    always @(negedge clock) begin
        if (selectN)
            addrIn <= ~addrIn;
    end
    task xfer(input [3:0] a, output [9:0] rx);
        integer i;
        begin
            @(negedge clock) selectN = 1'b0;
            repeat (5) @(posedge convClk);
            for (i = 0; i < 10; i = i + 1) begin
                addrIn = (i < 4) ? a[3 - i] : 1'b0;
                repeat (4) @(negedge clock);
                xferClk = 1'b1;
                repeat (4) @(negedge clock);
                rx[9 - i] = dataOut;
                xferClk = 1'b0;
            end
        end
    endtask
    task deselect(input integer n);
        begin
            @(negedge clock) selectN = 1'b1;
            repeat (n) @(posedge convClk);
        end
    endtask
    task select_low;
        @(negedge clock) selectN = 1'b0;
    endtask
    task wiggle;
        repeat (16) begin
            repeat (4) @(negedge clock);
            xferClk = ~xferClk;
        end
    endtask
endmodule // sadc_host_model

// File: sadc_monitor.sv
// timing checks on the converter control top
// assumes it is bound to sadc_control
`timescale 1ns/1ps
module sadc_monitor #(
    parameter CONV_CYCLES = 44
) (
    input wire        clock,
    input wire        rst_n,
    input wire        selectN,
    input wire        convClk,
    input wire        dataOutEn,
    input wire [11:0] chanSel,
    input wire        sampling,
    input wire        convBusy,
    input wire        resultPulse
);
    // ------------------------------------------------------------
    // conversion clock rises since busy began
    // ------------------------------------------------------------
    reg       cnvQ;
    reg       busyQ;
    reg [7:0] riseCntQ;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnvQ <= 1'b0;
            busyQ <= 1'b0;
            riseCntQ <= 8'h00;
        end else begin
            cnvQ <= convClk;
            busyQ <= convBusy;
            if (convBusy && !busyQ)
                riseCntQ <= 8'h00;
            else if (convClk && !cnvQ)
                riseCntQ <= riseCntQ + 8'h01;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_idle_off: assert property (@(posedge clock) disable iff (!rst_n) selectN [*5] |-> !dataOutEn)
        else $error("output enabled while deselected");
    chk_enable_on: assert property (@(posedge clock) disable iff (!rst_n) !selectN [*8] |-> dataOutEn)
        else $error("output not enabled while selected");
    chk_conv_len: assert property (@(posedge clock) disable iff (!rst_n)
        resultPulse |-> riseCntQ >= CONV_CYCLES - 1 && riseCntQ <= CONV_CYCLES + 1)
        else $error("conversion length wrong");
    chk_pulse_one: assert property (@(posedge clock) disable iff (!rst_n) resultPulse |=> !resultPulse)
        else $error("result pulse too long");
    chk_pulse_busy: assert property (@(posedge clock) disable iff (!rst_n)
        resultPulse |-> convBusy || $past(convBusy))
        else $error("result without conversion");
    chk_busy_start: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(convBusy) |-> sampling || $past(sampling))
        else $error("conversion began without sampling");
    chk_chan_onehot: assert property (@(posedge clock) disable iff (!rst_n) $onehot0(chanSel))
        else $error("selector not one-hot");
    chk_chan_hold: assert property (@(posedge clock) disable iff (!rst_n) selectN [*4] |=> $stable(chanSel))
        else $error("selector changed while deselected");
    chk_abort_stop: assert property (@(posedge clock) disable iff (!rst_n)
        convBusy && $fell(selectN) |-> ##[1:40] !convBusy)
        else $error("conversion not abandoned");
endmodule // sadc_monitor

bind sadc_control sadc_monitor #(.CONV_CYCLES(CONV_CYCLES)) chkU (.clock(clock), .rst_n(rst_n),
    .selectN(selectN), .convClk(convClk), .dataOutEn(dataOutEn), .chanSel(chanSel),
    .sampling(sampling), .convBusy(convBusy), .resultPulse(resultPulse));
